/* hw/spi_front.sv */
// Serial slave front end: frame decode, register map, information area and frame checks.
`timescale 1ns/1ps
`include "spi_front_cfg.svh"
module spi_front #(
  parameter logic [7:0] MAKER_ID = 8'hA5, // Arbitrary value.
  parameter logic [7:0] FAMILY_ID = 8'h3C, // Arbitrary value.
  parameter logic [31:0] PART_ID = 32'h1234_5678, // Arbitrary value.
  parameter logic [7:0] REVISION_ID = 8'h0B // Arbitrary value.
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Serial pins from the master.
  input wire logic chip_select_n,
  input wire logic sck,
  input wire logic sdi,
  // Serial data out pin.
  output spi_front_pkg::sdo_pin_s sdo,
  // Device side status sources and views.
  input wire logic [23:0] status_set,
  input wire logic [4:0] gsb_events,
  output logic [23:0] control_one,
  output logic [23:0] control_two,
  output logic [23:0] control_three,
  output logic [23:0] control_four,
  output logic [23:0] status_one,
  output logic [23:0] customer_trim_one,
  output logic [23:0] customer_trim_two,
  output logic serial_error_flag,
  output logic device_reset_flag
);
  import spi_front_pkg::*;

  // Double-flop synchronisers; only the second stage is read by logic.
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic sck_prev_q;
  logic cs_prev_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Reset values match the idle pins (selected high, clock low) so no false edge follows.
      meta_q <= 3'h4;
      sync_q <= 3'h4;
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      meta_q <= {chip_select_n, sck, sdi};
      sync_q <= meta_q;
      sck_prev_q <= sync_q[1];
      cs_prev_q <= sync_q[2];
    end
  end

  logic cs_n_s;
  logic sdi_s;
  logic sck_rise;
  logic sck_fall;
  logic frame_start;
  logic frame_end;
  assign cs_n_s = sync_q[2];
  assign sdi_s = sync_q[0];
  assign sck_rise = !cs_n_s && sync_q[1] && !sck_prev_q;
  assign sck_fall = !cs_n_s && !sync_q[1] && sck_prev_q;
  assign frame_start = cs_prev_q && !cs_n_s;
  assign frame_end = !cs_prev_q && cs_n_s;

  // Input shift register and rising-edge counter, cleared at frame start.
  logic [31:0] shift_in_q;
  logic [7:0] edge_cnt_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_in_q <= 32'h0000_0000;
      edge_cnt_q <= 8'h00;
    end else if (frame_start) begin
      shift_in_q <= 32'h0000_0000;
      edge_cnt_q <= 8'h00;
    end else if (sck_rise) begin
      // Long info frames keep their first 32 bits, so parity still covers the command.
      if (edge_cnt_q < 8'(`FRAME_BITS)) begin
        shift_in_q <= {shift_in_q[30:0], sdi_s};
      end
      if (edge_cnt_q != 8'hFF) begin
        edge_cnt_q <= edge_cnt_q + 8'h01;
      end
    end
  end

  // Op code captured on the second rise, so short frames are judged by their own kind.
  op_code_e frame_op_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_op_q <= OP_WRITE;
    end else if (frame_start) begin
      frame_op_q <= OP_WRITE;
    end else if (sck_rise && edge_cnt_q == 8'h01) begin
      frame_op_q <= op_code_e'({shift_in_q[0], sdi_s});
    end
  end

  // Information area lookup, used by the out-shifter and nowhere else decoded twice.
  function automatic logic [7:0] info_byte(input logic [5:0] a);
    case (a)
      `INFO_MAKER: info_byte = MAKER_ID;
      `INFO_FAMILY: info_byte = FAMILY_ID;
      `INFO_PART1: info_byte = PART_ID[31:24];
      `INFO_PART2: info_byte = PART_ID[23:16];
      `INFO_PART3: info_byte = PART_ID[15:8];
      `INFO_PART4: info_byte = PART_ID[7:0];
      `INFO_REV: info_byte = REVISION_ID;
      `INFO_MODE: info_byte = `VAL_MODE;
      `INFO_WD_KIND: info_byte = `VAL_WD_KIND;
      `INFO_WD_ADDR: info_byte = `VAL_WD_ADDR;
      `INFO_WD_INDEX: info_byte = `VAL_WD_INDEX;
      `INFO_PHASE: info_byte = `VAL_PHASE;
      `INFO_GSB_OPT: info_byte = `VAL_GSB_OPT;
      `INFO_SOFT_RST: info_byte = `VAL_SOFT_RST;
      default: info_byte = 8'h00;
    endcase
  endfunction

  // Application read data; unused addresses return zero and raise nothing.
  logic [23:0] app_rd;
  always_comb begin
    case (shift_in_q[5:0])
      `APP_CTRL1: app_rd = control_one;
      `APP_CTRL2: app_rd = control_two;
      `APP_CTRL3: app_rd = control_three;
      `APP_CTRL4: app_rd = control_four;
      `APP_STAT1: app_rd = status_one;
      `APP_TRIM1: app_rd = customer_trim_one;
      `APP_TRIM2: app_rd = customer_trim_two;
      default: app_rd = 24'h000000;
    endcase
  end

  // Global status byte; bit 7 is the NOR of the others.
  logic [7:0] global_status_byte;
  always_comb begin
    global_status_byte = {1'b0, device_reset_flag, serial_error_flag, gsb_events};
    global_status_byte[`GSB_NOT_BIT] = ~|global_status_byte[6:0];
  end

  // Output shifter: status byte loaded at frame start, payload after the eighth rise.
  // Info reads fill the tail with zeros, so the serial line is low after the byte.
  logic [31:0] shift_out_q;
  logic out_bit_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_out_q <= 32'h0000_0000;
      out_bit_q <= 1'b0;
    end else if (frame_start) begin
      shift_out_q <= {global_status_byte, 24'h000000};
      out_bit_q <= global_status_byte[7];
    end else if (sck_rise && edge_cnt_q == 8'h07) begin
      if (shift_in_q[6:5] == OP_INFO) begin
        // Bit 31 still shows the last status bit; the payload follows at the next fall.
        shift_out_q <= {shift_out_q[31], info_byte({shift_in_q[4:0], sdi_s}),
                        23'h000000};
      end else begin
        shift_out_q <= {shift_out_q[31], app_rd_next(shift_in_q[4:0], sdi_s), 7'h00};
      end
    end else if (sck_fall) begin
      shift_out_q <= {shift_out_q[30:0], 1'b0};
      out_bit_q <= shift_out_q[30];
    end
  end

  // Read data for the address that completes on the eighth rise.
  function automatic logic [23:0] app_rd_next(input logic [4:0] hi, input logic lo);
    logic [5:0] a;
    a = {hi, lo};
    case (a)
      `APP_CTRL1: app_rd_next = control_one;
      `APP_CTRL2: app_rd_next = control_two;
      `APP_CTRL3: app_rd_next = control_three;
      `APP_CTRL4: app_rd_next = control_four;
      `APP_STAT1: app_rd_next = status_one;
      `APP_TRIM1: app_rd_next = customer_trim_one;
      `APP_TRIM2: app_rd_next = customer_trim_two;
      default: app_rd_next = 24'h000000;
    endcase
  endfunction

  // Serial output pin, registered; enabled for the whole select period.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdo <= '0;
    end else begin
      sdo.sdo_oe <= !cs_n_s;
      sdo.sdo_o <= !cs_n_s && out_bit_q;
    end
  end

  // Frame checks evaluated at select release.
  frame_s fr;
  logic parity_ok;
  logic count_ok;
  logic stuck;
  logic frame_bad;
  logic frame_empty;
  assign fr = frame_s'(shift_in_q);
  assign parity_ok = ^shift_in_q;
  assign frame_empty = (edge_cnt_q == 8'h00);
  assign stuck = (shift_in_q == 32'h0000_0000) || (shift_in_q == 32'hFFFF_FFFF);
  always_comb begin
    if (frame_op_q == OP_INFO) begin
      count_ok = (edge_cnt_q >= 8'(`INFO_MIN_EDGES)) &&
                 (edge_cnt_q[2:0] == 3'h0);
    end else begin
      count_ok = (edge_cnt_q == 8'(`FRAME_BITS));
    end
  end
  // For a short info frame the address bits sit lower; only full frames act.
  assign frame_bad = !count_ok || !parity_ok || stuck;

  logic accept;
  logic soft_rst;
  logic clear_all;
  assign accept = frame_end && !frame_empty && !frame_bad && (edge_cnt_q == 8'(`FRAME_BITS));
  assign soft_rst = accept && fr.op == OP_INFO && fr.addr == `INFO_SOFT_RST;
  assign clear_all = soft_rst ||
                     (accept && fr.op == OP_READ_CLEAR && fr.addr == `APP_TRIM2);

  // Serial error flag: set on a rejected frame, shown next frame, cleared by a read-clear of the status register or by a clear-all.
  // A new failure in the clearing cycle wins so no error is lost.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_error_flag <= 1'b0;
    end else if (frame_end && !frame_empty && frame_bad) begin
      serial_error_flag <= 1'b1;
    end else if (accept && fr.op == OP_READ_CLEAR && fr.addr == `APP_STAT1) begin
      serial_error_flag <= 1'b0;
    end else if (clear_all) begin
      serial_error_flag <= 1'b0;
    end
  end

  // Device reset flag: raised at power-on, cleared by a status clear.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      device_reset_flag <= 1'b1;
    end else if (clear_all ||
                 (accept && fr.op == OP_READ_CLEAR && fr.addr == `APP_STAT1)) begin
      device_reset_flag <= 1'b0;
    end
  end

  // Control registers: written by accepted writes, returned to default by soft reset and held there while the reset flag is set.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      control_one <= `CTRL_RESET;
      control_two <= `CTRL_RESET;
      control_three <= `CTRL_RESET;
      control_four <= `CTRL_RESET;
    end else if (soft_rst || device_reset_flag) begin
      control_one <= `CTRL_RESET;
      control_two <= `CTRL_RESET;
      control_three <= `CTRL_RESET;
      control_four <= `CTRL_RESET;
    end else if (accept && fr.op == OP_WRITE) begin
      case (fr.addr)
        `APP_CTRL1: control_one <= fr.data;
        `APP_CTRL2: control_two <= fr.data;
        `APP_CTRL3: control_three <= fr.data;
        `APP_CTRL4: control_four <= fr.data;
        default: ;
      endcase
    end
  end

  // Trim registers; writes blocked once the lock bit in the second one is set.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      customer_trim_one <= `TRIM_RESET;
      customer_trim_two <= `TRIM_RESET;
    end else if (accept && fr.op == OP_WRITE &&
                 !customer_trim_two[`TRIM_LOCK_BIT]) begin
      if (fr.addr == `APP_TRIM1) begin
        customer_trim_one <= fr.data;
      end
      if (fr.addr == `APP_TRIM2) begin
        customer_trim_two <= fr.data;
      end
    end
  end

  // Status register: sticky bits, set beats clear.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_one <= 24'h000000;
    end else if (clear_all ||
                 (accept && fr.op == OP_READ_CLEAR && fr.addr == `APP_STAT1)) begin
      status_one <= status_set;
    end else begin
      status_one <= status_one | status_set;
    end
  end
endmodule

/* shared/spi_front_cfg.svh */
// Constants of the serial front end: offsets, field positions, reset values, timing.
`ifndef SPI_FRONT_CFG_SVH
`define SPI_FRONT_CFG_SVH
`define FRAME_BITS 32
`define APP_CTRL1 6'h01
`define APP_CTRL2 6'h02
`define APP_CTRL3 6'h03
`define APP_CTRL4 6'h04
`define APP_STAT1 6'h06
`define APP_TRIM1 6'h3E
`define APP_TRIM2 6'h3F
`define INFO_MAKER 6'h00
`define INFO_FAMILY 6'h01
`define INFO_PART1 6'h02
`define INFO_PART2 6'h03
`define INFO_PART3 6'h04
`define INFO_PART4 6'h05
`define INFO_REV 6'h0A
`define INFO_MODE 6'h10
`define INFO_WD_KIND 6'h11
`define INFO_WD_ADDR 6'h13
`define INFO_WD_INDEX 6'h14
`define INFO_PHASE 6'h20
`define INFO_GSB_OPT 6'h3E
`define INFO_SOFT_RST 6'h3F
`define VAL_MODE 8'h31
`define VAL_WD_KIND 8'h4A
`define VAL_WD_ADDR 8'h44
`define VAL_WD_INDEX 8'hD7
`define VAL_PHASE 8'h55
`define VAL_GSB_OPT 8'h00
`define VAL_SOFT_RST 8'h00
`define CTRL_RESET 24'h000000
`define TRIM_RESET 24'h000000
`define GSB_NOT_BIT 7
`define GSB_RESET_BIT 6
`define GSB_SERR_BIT 5
`define STAT_SERR_BIT 0
`define TRIM_LOCK_BIT 1
`define INFO_MIN_EDGES 16
`define INFO_EDGE_STEP 8
`define WD_PERIOD_MS 50
`endif

/* shared/spi_front_pkg.sv */
// Types shared by the serial front end.
package spi_front_pkg;
  typedef enum logic [1:0] {
    OP_WRITE = 2'b00,
    OP_READ = 2'b01,
    OP_READ_CLEAR = 2'b10,
    OP_INFO = 2'b11
  } op_code_e;
  typedef struct packed {
    op_code_e op;
    logic [5:0] addr;
    logic [23:0] data;
  } frame_s;
  typedef struct packed {
    logic sdo_o;
    logic sdo_oe;
  } sdo_pin_s;
endpackage

/* verification/spi_front_asserts.sv */
// Port-level checks of the serial front end, bound to its top module.
`timescale 1ns/1ps
module spi_front_asserts (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Serial pins.
  input wire logic chip_select_n,
  input spi_front_pkg::sdo_pin_s sdo,
  // Device side.
  input wire logic [23:0] status_set,
  input wire logic [4:0] gsb_events,
  input wire logic [23:0] control_one,
  input wire logic [23:0] control_two,
  input wire logic [23:0] control_three,
  input wire logic [23:0] control_four,
  input wire logic [23:0] status_one,
  input wire logic [23:0] customer_trim_one,
  input wire logic [23:0] customer_trim_two,
  input wire logic serial_error_flag,
  input wire logic device_reset_flag
);
  import spi_front_pkg::*;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // A settled idle period, then select falls.
  sequence sel_start;
    chip_select_n [*4] ##1 !chip_select_n;
  endsequence
  // The inverted summary bit is out before the first clock can arrive.
  sequence first_bit_ready;
    ##5 sdo.sdo_oe && (sdo.sdo_o != (serial_error_flag || device_reset_flag || (|gsb_events)));
  endsequence
  chk_idle_quiet: assert property (chip_select_n [*5] |-> !sdo.sdo_oe && !sdo.sdo_o)
    else $error("serial output active while deselected");
  chk_status_first: assert property (sel_start |-> first_bit_ready)
    else $error("first status bit wrong");
  chk_reset_hold: assert property (device_reset_flag |->
      {control_one, control_two, control_three, control_four} == 96'h0)
    else $error("control register off default while reset flag set");
  chk_regs_framed: assert property ($changed({control_one, control_two, control_three,
      control_four, customer_trim_one, customer_trim_two}) |-> chip_select_n)
    else $error("register changed inside a frame");
  chk_trim_locked: assert property (customer_trim_two[1] && $stable(customer_trim_two[1])
      |-> $stable(customer_trim_one))
    else $error("locked trim register changed");
  chk_error_framed: assert property ($rose(serial_error_flag) |-> chip_select_n)
    else $error("serial error raised inside a frame");
  chk_clear_framed: assert property ($changed(status_one) && $past(status_set) == 24'h0
      |-> chip_select_n)
    else $error("status cleared inside a frame");
  chk_reset_framed: assert property ($rose(device_reset_flag) |-> chip_select_n)
    else $error("reset flag raised inside a frame");
endmodule
bind spi_front spi_front_asserts u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .chip_select_n(chip_select_n), .sdo(sdo), .status_set(status_set), .gsb_events(gsb_events),
  .control_one(control_one), .control_two(control_two), .control_three(control_three),
  .control_four(control_four), .status_one(status_one), .customer_trim_one(customer_trim_one),
  .customer_trim_two(customer_trim_two), .serial_error_flag(serial_error_flag),
  .device_reset_flag(device_reset_flag));

/* verification/spi_master_model.sv */
// Behavioural serial master that frames, clocks and samples the front end.
`timescale 1ns/1ps
module spi_master_model (
  // Serial pins toward the device.
  output logic chip_select_n,
  output logic sck,
  output logic sdi,
  // Serial data from the device.
  input spi_front_pkg::sdo_pin_s sdo
);
  import spi_front_pkg::*;
  // Idle: deselected, clock low and still.
  initial begin
    chip_select_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end
  // One frame, bit 31 first; bit 0 is made odd parity unless a fault is asked for.
  task automatic xfer(input logic [31:0] f, input int n, input logic bad,
      output logic [31:0] rx);
    logic [31:0] w;
    w = {f[31:1], (~^f[31:1]) ^ bad};
    rx = 32'h0;
    chip_select_n = 1'b0;
    #1300;
    // Data changes as the clock falls; output is read just before that fall.
    for (int i = 0; i < n; i++) begin
      sdi = (i < 32) ? w[31 - i] : 1'b0;
      #400 sck = 1'b1;
      #400 rx = {rx[30:0], sdo.sdo_o};
      sck = 1'b0;
    end
    #1300 sdi = ~sdi; // A released line must not keep its last level.
    chip_select_n = 1'b1;
    #1300;
  endtask
endmodule

/* verification/tb.sv */
// Self-checking bench of the serial front end driven by the master model.
`timescale 1ns/1ps
`include "spi_front_cfg.svh"
module tb;
  import spi_front_pkg::*;
  localparam logic [7:0] MK = 8'h6E; // Arbitrary value.
  localparam logic [7:0] FM = 8'h39; // Arbitrary value.
  localparam logic [31:0] PN = 32'h7A1B_2C3D; // Arbitrary value.
  localparam logic [7:0] RV = 8'h0C; // Arbitrary value.
  logic sys_clk, rst_n, chip_select_n, sck, sdi, serial_error_flag, device_reset_flag;
  logic [4:0] gsb_events;
  logic [23:0] status_set, control_one, control_two, control_three, control_four;
  logic [23:0] status_one, customer_trim_one, customer_trim_two;
  logic [31:0] rx;
  sdo_pin_s sdo;
  int n_errors = 0;
  int n_tests = 0;
  // Information addresses and the bytes they return.
  logic [5:0] i_adr [13] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h0A, 6'h10, 6'h11,
    6'h13, 6'h14, 6'h20, 6'h3E};
  logic [7:0] i_val [13] = '{MK, FM, PN[31:24], PN[23:16], PN[15:8], PN[7:0], RV, 8'h31,
    8'h4A, 8'h44, 8'hD7, 8'h55, 8'h00};
  spi_front #(.MAKER_ID(MK), .FAMILY_ID(FM), .PART_ID(PN), .REVISION_ID(RV)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .chip_select_n(chip_select_n), .sck(sck), .sdi(sdi),
    .sdo(sdo), .status_set(status_set), .gsb_events(gsb_events), .control_one(control_one),
    .control_two(control_two), .control_three(control_three), .control_four(control_four),
    .status_one(status_one), .customer_trim_one(customer_trim_one),
    .customer_trim_two(customer_trim_two), .serial_error_flag(serial_error_flag),
    .device_reset_flag(device_reset_flag));
  spi_master_model u_mst (.chip_select_n(chip_select_n), .sck(sck), .sdi(sdi), .sdo(sdo));
  // Compares a seen value with its expected value and counts both.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Frames start off the system clock edge so no sampling race arises.
  task automatic frame(input op_code_e op, input logic [5:0] a, input logic [23:0] d,
      input int n, input logic bad = 1'b0);
    @(posedge sys_clk);
    #13 u_mst.xfer({op, a, d}, n, bad, rx);
  endtask
  // One cycle of status input, then time for it to settle.
  task automatic raise_status(input logic [23:0] v);
    @(posedge sys_clk) status_set <= v;
    @(posedge sys_clk) status_set <= 24'h0;
    repeat (2) @(posedge sys_clk);
    #10;
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // A hang ends the run as a failure.
  initial begin
    #4000000;
    n_errors++;
    give_verdict();
  end
  initial begin
    rst_n = 1'b0;
    status_set = 24'h0;
    gsb_events = 5'h0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      frame(OP_INFO, i_adr[i], 24'h0, 32);
      check("info", rx[23:0], {i_val[i], 16'h0});
    end
    check("gsb after reset", rx[31:29], 3'b010);
    frame(OP_READ_CLEAR, 6'h06, 24'h0, 32);
    for (int i = 1; i <= 4; i++) begin
      frame(OP_WRITE, 6'(i), {4'(i), 20'hB5C46}, 32);
      frame(OP_READ, 6'(i), 24'h0, 32);
      check("ctrl read", rx[23:1], {4'(i), 19'h5AE23});
    end
    check("ctrl ports", {control_one[23:20], control_two[23:20], control_three[23:20],
      control_four[23:20], device_reset_flag}, {16'h1234, 1'b0});
    // A short frame is dropped and flagged, then reported in the next status byte.
    frame(OP_WRITE, 6'h01, 24'h0, 31);
    check("short frame", {control_one[23:20], serial_error_flag}, 5'h03);
    frame(OP_READ, 6'h01, 24'h0, 32);
    check("error bit", rx[29], 1'b1);
    frame(OP_READ_CLEAR, 6'h06, 24'h0, 32);
    frame(OP_WRITE, 6'h01, 24'h0, 0);
    check("no clock", {serial_error_flag, control_one[23:20]}, 5'h01);
    frame(OP_WRITE, 6'h01, 24'h0, 32, 1'b1);
    check("parity", {control_one[23:20], serial_error_flag}, 5'h03);
    frame(OP_READ_CLEAR, 6'h06, 24'h0, 32);
    frame(OP_INFO, 6'h20, 24'h0, 16);
    check("info 16", {rx[15:0], serial_error_flag}, {16'h8055, 1'b0});
    frame(OP_INFO, 6'h20, 24'h0, 40);
    check("info 40", {rx[31:1], serial_error_flag}, {8'h55, 24'h0});
    frame(OP_INFO, 6'h20, 24'h0, 20);
    check("info 20", serial_error_flag, 1'b1);
    frame(OP_READ_CLEAR, 6'h06, 24'h0, 32);
    raise_status(24'h000008);
    check("status set", status_one, 24'h000008);
    frame(OP_READ_CLEAR, 6'h3F, 24'h0, 32);
    check("clear all", status_one, 24'h0);
    // Soft reset with an all-zero payload returns controls and clears status.
    frame(OP_WRITE, 6'h02, 24'h7000F0, 32);
    raise_status(24'h000010);
    frame(OP_INFO, 6'h3F, 24'h0, 32);
    check("soft reset", {rx[23:16], control_two[23:16], status_one[15:0]}, 32'h0);
    frame(OP_READ_CLEAR, 6'h06, 24'h0, 32);
    @(posedge sys_clk) gsb_events <= 5'h04;
    frame(OP_READ, 6'h20, 24'h0, 32);
    check("unused", {rx[31], serial_error_flag}, 2'b00);
    @(posedge sys_clk) gsb_events <= 5'h00;
    // Lock the trims, then try to overwrite the first one.
    frame(OP_WRITE, 6'h3E, 24'h3C0000, 32);
    frame(OP_WRITE, 6'h3F, 24'h000002, 32);
    frame(OP_WRITE, 6'h3E, 24'h500000, 32);
    frame(OP_READ, 6'h3E, 24'h0, 32);
    check("trim lock", {rx[23:16], customer_trim_one[23:16], customer_trim_two[1]},
      {16'h3C3C, 1'b1});
    give_verdict();
  end
endmodule
